// [fcp_regs.sv]
// Flash cache, access-mode and protection registers with busy timing.
// Assumes APB master on pclk; cache events and op starts from pclk logic.
`timescale 1ns/1ns

// Operation
// [RULE1] Partial erase duration register in milliseconds, resets to 10.
// [RULE2] Software issues enough partial steps to fully erase a page.
// [RULE3] Cache on bit enables cache; clearing it invalidates all entries.
// [RULE4] With profiling on, hits and misses increment their counters; the code counts them only while cache_on_q is also set.
// [RULE5] Readable writable 32-bit hit counter, reset zero, cleared by writing zero.
// [RULE6] Readable writable 32-bit miss counter, reset zero, cleared by writing zero.
// [RULE7] Access mode: 0 read only, 1 write enabled, 2 erase enabled.
// [RULE8] Software writes only one-hot access mode values.
// [RULE9] Write or erase mode invalidates cache and keeps it invalidated.
// [RULE10] Software selects write or erase only while actually using it.
// [RULE11] Write-only register, bit 0 set lets non-secure code set port protection.
// [RULE12] Protection write acts only with the valid key in upper bits.
// [RULE13] Software writes each flash word at most twice between erases.
// [RULE14] Word programming finishes within 43 us, busy meanwhile.
// [RULE15] Page erase finishes within 87 ms, busy meanwhile.
// [RULE16] Whole flash erase finishes within 173 ms, busy meanwhile.
// [RULE17] Each partial erase step adds at most 1.08 ms set-up time.
module fcp_regs import fcp_pkg::*; #(
    parameter int CYC_WRITE = FCP_CYC_WRITE,
    parameter int CYC_PAGE  = FCP_CYC_PAGE,
    parameter int CYC_ALL   = FCP_CYC_ALL,
    parameter int CYC_SETUP = FCP_CYC_SETUP,
    parameter int CYC_MS    = FCP_CYC_PER_MS
) (
    // Clock, reset, enable
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata_q,
    output logic             pready_q,
    output logic             pslverr_q,
    // Cache events
    input  wire logic        icache_hit,
    input  wire logic        icache_miss,
    // Flash operation starts
    input  wire logic        word_write_start,
    input  wire logic        page_erase_start,
    input  wire logic        erase_all_start,
    input  wire logic        partial_erase_start,
    // Status and control to the unit
    output logic             flash_busy_q,
    output logic             cache_on_q,
    output logic             cache_profiling_on_q,
    output logic             cache_invalidate_q,
    output logic             write_enabled_q,
    output logic             erase_enabled_q,
    output logic             access_port_protection_q
);
    logic [31:0]          partial_erase_duration_q;
    logic [1:0]           nonsecure_access_mode_q;
    logic [31:0]          icache_hit_counter;
    logic [31:0]          icache_miss_counter;
    logic [FCP_TMR_W-1:0] timer_q;
    logic [FCP_TMR_W-1:0] partial_cyc;
    fcp_state_e           state_q;
    logic                 wr_acc;
    logic                 rd_acc;
    logic                 mapped;
    logic                 start_any;
    logic [31:0]          rd_mux;

    // ==========================================================
    // APB decode
    assign wr_acc = psel & penable & pready_q & pwrite;
    assign rd_acc = psel & penable & ~pready_q & ~pwrite;

    always_comb begin
        mapped = 1'b1;
        rd_mux = 32'h00000000;
        case (paddr)
            FCP_OFF_PART_ERASE: rd_mux = partial_erase_duration_q;
            FCP_OFF_ICACHE_CFG: begin
                rd_mux[FCP_CACHE_ON_BIT]   = cache_on_q;
                rd_mux[FCP_CACHE_PROF_BIT] = cache_profiling_on_q;
            end
            FCP_OFF_ICACHE_HIT:  rd_mux = icache_hit_counter;
            FCP_OFF_ICACHE_MISS: rd_mux = icache_miss_counter;
            FCP_OFF_NS_MODE:     rd_mux = {30'h0, nonsecure_access_mode_q};
            FCP_OFF_NS_PROTECT:  rd_mux = 32'h00000000;
            default:             mapped = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h00000000;
        end else if (ce) begin
            pready_q  <= psel & penable & ~pready_q;
            pslverr_q <= psel & penable & ~pready_q & ~mapped;
            if (rd_acc) begin
                prdata_q <= rd_mux;
            end
        end
    end

    // ==========================================================
    // Configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            partial_erase_duration_q <= FCP_PART_ERASE_RST;
        end else if (ce && wr_acc && paddr == FCP_OFF_PART_ERASE) begin
            partial_erase_duration_q <= pwdata; // [RULE1]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cache_on_q           <= 1'b0;
            cache_profiling_on_q <= 1'b0;
        end else if (ce && wr_acc && paddr == FCP_OFF_ICACHE_CFG) begin
            cache_on_q           <= pwdata[FCP_CACHE_ON_BIT]; // [RULE3]
            cache_profiling_on_q <= pwdata[FCP_CACHE_PROF_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nonsecure_access_mode_q <= FCP_MODE_READ;
            write_enabled_q         <= 1'b0;
            erase_enabled_q         <= 1'b0;
        end else if (ce && wr_acc && paddr == FCP_OFF_NS_MODE) begin
            nonsecure_access_mode_q <= pwdata[1:0];
            write_enabled_q         <= pwdata[1:0] == FCP_MODE_WRITE; // [RULE7]
            erase_enabled_q         <= pwdata[1:0] == FCP_MODE_ERASE; // [RULE7]
        end
    end

    // ==========================================================
    // Cache invalidate: while off, or while write or erase mode is held
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cache_invalidate_q <= 1'b1;
        end else if (ce) begin
            cache_invalidate_q <= ~cache_on_q // [RULE3]
                                | nonsecure_access_mode_q == FCP_MODE_WRITE // [RULE9]
                                | nonsecure_access_mode_q == FCP_MODE_ERASE; // [RULE9]
        end
    end

    // ==========================================================
    // Keyed protection set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            access_port_protection_q <= 1'b0;
        end else if (ce && wr_acc && paddr == FCP_OFF_NS_PROTECT) begin
            if (pwdata[31:FCP_KEY_LSB] == FCP_KEY_VALID && pwdata[FCP_PROT_SET_BIT]) begin // [RULE12]
                access_port_protection_q <= 1'b1; // [RULE11]
            end
        end
    end

    // ==========================================================
    // Hit and miss counters
    fcp_event_counter u_hit (
        .pclk        (pclk),
        .presetn     (presetn),
        .ce          (ce),
        .count_en    (cache_profiling_on_q & cache_on_q),
        .event_pulse (icache_hit),
        .load        (wr_acc && paddr == FCP_OFF_ICACHE_HIT),
        .load_value  (pwdata),
        .count_q     (icache_hit_counter)
    ); // [RULE4] [RULE5]

    fcp_event_counter u_miss (
        .pclk        (pclk),
        .presetn     (presetn),
        .ce          (ce),
        .count_en    (cache_profiling_on_q & cache_on_q),
        .event_pulse (icache_miss),
        .load        (wr_acc && paddr == FCP_OFF_ICACHE_MISS),
        .load_value  (pwdata),
        .count_q     (icache_miss_counter)
    ); // [RULE4] [RULE6]

    // ==========================================================
    // Busy timer; starts ignored while busy or mode not allowing them
    assign partial_cyc = FCP_TMR_W'({18'h0, partial_erase_duration_q} * FCP_TMR_W'(CYC_MS))
                       + FCP_TMR_W'(CYC_SETUP); // [RULE17]
    assign start_any   = (word_write_start & write_enabled_q)
                       | ((page_erase_start | erase_all_start | partial_erase_start) & erase_enabled_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q      <= FCP_IDLE;
            timer_q      <= '0;
            flash_busy_q <= 1'b0;
        end else if (ce) begin
            case (state_q)
                FCP_IDLE: begin
                    if (start_any) begin
                        state_q      <= FCP_BUSY;
                        flash_busy_q <= 1'b1;
                        if (word_write_start & write_enabled_q) begin
                            timer_q <= FCP_TMR_W'(CYC_WRITE - 1); // [RULE14]
                        end else if (erase_all_start) begin
                            timer_q <= FCP_TMR_W'(CYC_ALL - 1); // [RULE16]
                        end else if (page_erase_start) begin
                            timer_q <= FCP_TMR_W'(CYC_PAGE - 1); // [RULE15]
                        end else begin
                            timer_q <= partial_cyc - FCP_TMR_W'(1); // [RULE1]
                        end
                    end
                end
                FCP_BUSY: begin
                    if (timer_q == '0) begin
                        state_q      <= FCP_IDLE;
                        flash_busy_q <= 1'b0;
                    end else begin
                        timer_q <= timer_q - FCP_TMR_W'(1);
                    end
                end
                default: begin
                    state_q      <= FCP_IDLE;
                    flash_busy_q <= 1'b0;
                end
            endcase
        end
    end
endmodule : fcp_regs

// [fcp_pkg.sv]
// Constants shared by the flash cache and protection register block.
// Assumes a 100 MHz pclk and 32-bit APB data.
package fcp_pkg;
    // ==========================================================
    // Register offsets
    localparam logic [11:0] FCP_OFF_PART_ERASE   = 12'h51C;
    localparam logic [11:0] FCP_OFF_ICACHE_CFG   = 12'h540;
    localparam logic [11:0] FCP_OFF_ICACHE_HIT   = 12'h548;
    localparam logic [11:0] FCP_OFF_ICACHE_MISS  = 12'h54C;
    localparam logic [11:0] FCP_OFF_NS_MODE      = 12'h584;
    localparam logic [11:0] FCP_OFF_NS_PROTECT   = 12'h588;

    // ==========================================================
    // Field positions and reset values
    localparam int          FCP_CACHE_ON_BIT     = 0;
    localparam int          FCP_CACHE_PROF_BIT   = 8;
    localparam int          FCP_PROT_SET_BIT     = 0;
    localparam int          FCP_KEY_LSB          = 4;
    localparam logic [27:0] FCP_KEY_VALID        = 28'hAFBE5A7;
    localparam logic [31:0] FCP_PART_ERASE_RST   = 32'h0000000A;
    localparam logic [31:0] FCP_ZERO_RST         = 32'h00000000;

    // ==========================================================
    // Access modes
    localparam logic [1:0]  FCP_MODE_READ        = 2'h0;
    localparam logic [1:0]  FCP_MODE_WRITE       = 2'h1;
    localparam logic [1:0]  FCP_MODE_ERASE       = 2'h2;

    // ==========================================================
    // Timing
    localparam int          FCP_CLK_MHZ          = 100;
    localparam int          FCP_T_WRITE_US       = 43;
    localparam int          FCP_T_PAGE_MS        = 87;
    localparam int          FCP_T_ALL_MS         = 173;
    localparam int          FCP_T_SETUP_US       = 1080;
    localparam int          FCP_CYC_PER_MS       = FCP_CLK_MHZ * 1000;
    localparam int          FCP_CYC_WRITE        = FCP_T_WRITE_US * FCP_CLK_MHZ;
    localparam int          FCP_CYC_PAGE         = FCP_T_PAGE_MS * FCP_CYC_PER_MS;
    localparam int          FCP_CYC_ALL          = FCP_T_ALL_MS * FCP_CYC_PER_MS;
    localparam int          FCP_CYC_SETUP        = FCP_T_SETUP_US * FCP_CLK_MHZ;
    localparam int          FCP_TMR_W            = 50;

    typedef enum logic [1:0] {
        FCP_IDLE,
        FCP_BUSY
    } fcp_state_e;
endpackage : fcp_pkg

// [fcp_event_counter.sv]
// Software-writable 32-bit event counter.
// Assumes event pulses come from logic on pclk.
`timescale 1ns/1ns
module fcp_event_counter (
    // Clock, reset and enable
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    // Control
    input  wire logic        count_en,
    input  wire logic        event_pulse,
    input  wire logic        load,
    input  wire logic [31:0] load_value,
    // Value
    output logic      [31:0] count_q
);
    logic [31:0] inc;

    assign inc = {31'h0, count_en & event_pulse};

    // ==========================================================
    // Counter, an event in the load cycle still counts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= 32'h00000000;
        end else if (ce) begin
            if (load) begin
                count_q <= load_value + inc;
            end else begin
                count_q <= count_q + inc;
            end
        end
    end
endmodule : fcp_event_counter

// [fcp_regs_asserts.sv]
// Assertions on the ports of the flash cache and protection register block.
// Assumes fcp_pkg is compiled first; bound to every fcp_regs instance.
`timescale 1ns/1ns
module fcp_regs_asserts import fcp_pkg::*; #(
    parameter int CYC_WRITE = 5,
    parameter int CYC_PAGE  = 20,
    parameter int CYC_ALL   = 40
) (
    // Clock and APB
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready_q,
    // Flash operations
    input wire logic        word_write_start,
    input wire logic        page_erase_start,
    input wire logic        erase_all_start,
    input wire logic        flash_busy_q,
    // Control outputs
    input wire logic        cache_on_q,
    input wire logic        cache_invalidate_q,
    input wire logic        write_enabled_q,
    input wire logic        erase_enabled_q,
    input wire logic        access_port_protection_q
);
    // ==========================================================
    // Busy run tracking
    logic        wr_done;
    int unsigned run_q;
    int unsigned kind_q;
    int unsigned kind_d;
    assign wr_done = psel && penable && pready_q && pwrite;
    always_comb begin
        kind_d = 0;
        if (word_write_start && write_enabled_q)
            kind_d = CYC_WRITE;
        else if (erase_all_start && erase_enabled_q)
            kind_d = CYC_ALL;
        else if (page_erase_start && erase_enabled_q)
            kind_d = CYC_PAGE;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_q  <= 0;
            kind_q <= 0;
        end else begin
            run_q <= flash_busy_q ? run_q + 1 : 0;
            if (!flash_busy_q)
                kind_q <= kind_d;
        end
    end
    // ==========================================================
    // Properties
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_CACHE_ON: assert property (
        $past(wr_done && paddr == FCP_OFF_ICACHE_CFG) |-> cache_on_q == $past(pwdata[0]))
        else $error("cache on bit not loaded");
    AST_INVAL_OFF: assert property (
        !cache_on_q && $past(!cache_on_q) |-> cache_invalidate_q)
        else $error("cache off but not invalidated");
    AST_MODE_SET: assert property (
        $past(wr_done && paddr == FCP_OFF_NS_MODE) |-> (write_enabled_q == ($past(pwdata[1:0]) == FCP_MODE_WRITE))
        && (erase_enabled_q == ($past(pwdata[1:0]) == FCP_MODE_ERASE)))
        else $error("access mode decode wrong");
    AST_INVAL_MODE: assert property (
        (write_enabled_q || erase_enabled_q) && $past(write_enabled_q || erase_enabled_q) |-> cache_invalidate_q)
        else $error("write or erase mode without invalidate");
    AST_PROT_HOLD: assert property (
        $past(access_port_protection_q) |-> access_port_protection_q)
        else $error("protection dropped");
    AST_PROT_KEY: assert property (
        $rose(access_port_protection_q) |-> $past(wr_done && paddr == FCP_OFF_NS_PROTECT
        && pwdata[31:4] == FCP_KEY_VALID && pwdata[0]))
        else $error("protection set without keyed write");
    AST_WORD_TIME: assert property (
        $fell(flash_busy_q) && kind_q == CYC_WRITE |-> run_q == CYC_WRITE)
        else $error("word write busy length wrong");
    AST_PAGE_TIME: assert property (
        $fell(flash_busy_q) && kind_q == CYC_PAGE |-> run_q == CYC_PAGE)
        else $error("page erase busy length wrong");
    AST_ALL_TIME: assert property (
        $fell(flash_busy_q) && kind_q == CYC_ALL |-> run_q == CYC_ALL)
        else $error("erase all busy length wrong");
endmodule : fcp_regs_asserts

bind fcp_regs fcp_regs_asserts #(.CYC_WRITE(CYC_WRITE), .CYC_PAGE(CYC_PAGE), .CYC_ALL(CYC_ALL)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready_q(pready_q), .word_write_start(word_write_start),
    .page_erase_start(page_erase_start), .erase_all_start(erase_all_start), .flash_busy_q(flash_busy_q),
    .cache_on_q(cache_on_q), .cache_invalidate_q(cache_invalidate_q), .write_enabled_q(write_enabled_q),
    .erase_enabled_q(erase_enabled_q), .access_port_protection_q(access_port_protection_q)
);

// [fcp_regs_bench.sv]
// Self-checking bench for fcp_regs over APB with random cache events.
// Assumes fcp_pkg and the checker file are compiled first.
`timescale 1ns/1ns
module fcp_regs_bench import fcp_pkg::*;;
    // ==========================================================
    // Signals
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, hit = 0, miss = 0, err, ce = 1;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rd;
    logic [3:0]  starts = 0;
    wire logic [31:0] prdata;
    wire logic   pready, pslverr, busy, inval, we, ee, prot, con, cpo;
    int          n_errors = 0, checks = 0, seed = 11, cyc = 0, n, eh = 0, em = 0;
    logic [31:0] r;
    logic [11:0] offs [4] = '{FCP_OFF_PART_ERASE, FCP_OFF_ICACHE_CFG, FCP_OFF_ICACHE_HIT, FCP_OFF_ICACHE_MISS};

    fcp_regs #(.CYC_WRITE(5), .CYC_PAGE(20), .CYC_ALL(40), .CYC_SETUP(3), .CYC_MS(4)) i_dut (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata), .pready_q(pready), .pslverr_q(pslverr),
        .icache_hit(hit), .icache_miss(miss), .word_write_start(starts[0]), .page_erase_start(starts[1]),
        .erase_all_start(starts[2]), .partial_erase_start(starts[3]), .flash_busy_q(busy), .cache_on_q(con),
        .cache_profiling_on_q(cpo), .cache_invalidate_q(inval), .write_enabled_q(we), .erase_enabled_q(ee),
        .access_port_protection_q(prot));

    // ==========================================================
    // Clock, timeout and helpers
    initial forever #5 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_errors++;
            final_report();
        end
    end
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'h1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    function automatic int exp_busy(input int k, input int dur);
        exp_busy = k == 0 ? 5 : k == 1 ? 20 : k == 2 ? 40 : k == 3 || k == 5 ? dur * 4 + 3 : 0;
    endfunction : exp_busy

    // ==========================================================
    // Tests
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        chk("inval reset", 32'h1, inval);
        foreach (offs[i]) begin
            apb(1'h0, offs[i], 32'h0);
            chk("reset", i == 0 ? FCP_PART_ERASE_RST : FCP_ZERO_RST, rd);
        end
        foreach (offs[i]) begin
            r = $random(seed);
            apb(1'h1, offs[i], r);
            apb(1'h0, offs[i], 32'h0);
            chk("rw", i == 1 ? r & 32'h101 : r, rd);
        end
        apb(1'h0, 12'h560, 32'h0);
        chk("unmapped err", 32'h1, err);
        $display("test registers done");
        for (int j = 2; j < 4; j++) begin
            apb(1'h1, offs[j], 32'h0);
            apb(1'h0, offs[j], 32'h0);
            chk("clear", 32'h0, rd);
        end
        for (int p = 0; p < 3; p++) begin
            apb(1'h1, FCP_OFF_ICACHE_CFG, p == 1 ? 32'h1 : 32'h101);
            @(posedge pclk);
            chk("cache on", 32'h1, con);
            chk("profiling on", p != 1, cpo);
            ce <= p != 2;
            for (int i = 0; i < 40; i++) begin
                r = $random(seed);
                {hit, miss} <= r[1:0];
                @(posedge pclk);
                eh += p ? 0 : r[1];
                em += p ? 0 : r[0];
            end
            {hit, miss} <= 2'h0;
            ce          <= 1'h1;
            apb(1'h0, FCP_OFF_ICACHE_HIT, 32'h0);
            chk("hits", eh, rd);
            apb(1'h0, FCP_OFF_ICACHE_MISS, 32'h0);
            chk("misses", em, rd);
        end
        $display("test counters done");
        for (int k = 1; k < 4; k++) begin
            apb(1'h1, FCP_OFF_NS_MODE, k % 3);
            repeat (2) @(posedge pclk);
            chk("write mode", k == 1, we);
            chk("erase mode", k == 2, ee);
            chk("inval mode", k != 3, inval);
        end
        apb(1'h1, FCP_OFF_ICACHE_CFG, 32'h0);
        repeat (2) @(posedge pclk);
        chk("inval off", 32'h1, inval);
        $display("test modes done");
        apb(1'h1, FCP_OFF_PART_ERASE, 32'h2);
        for (int k = 0; k < 6; k++) begin
            apb(1'h1, FCP_OFF_NS_MODE, k == 0 ? 32'h1 : 32'h2);
            starts <= 4'h1 << (k == 5 ? 3 : k % 4);
            @(posedge pclk);
            starts <= 4'h0;
            n = 0;
            repeat (60) begin
                @(posedge pclk);
                n += busy;
            end
            chk("busy cycles", exp_busy(k, 2), n);
            chk("busy end", 32'h0, busy);
        end
        apb(1'h1, FCP_OFF_NS_MODE, 32'h0);
        $display("test busy done");
        apb(1'h1, FCP_OFF_NS_PROTECT, {FCP_KEY_VALID ^ 28'h1, 4'h1});
        @(posedge pclk);
        chk("protect bad key", 32'h0, prot);
        apb(1'h1, FCP_OFF_NS_PROTECT, {FCP_KEY_VALID, 4'h1});
        @(posedge pclk);
        chk("protect", 32'h1, prot);
        apb(1'h0, FCP_OFF_NS_PROTECT, 32'h0);
        chk("protect read", 32'h0, rd);
        $display("test protection done");
        final_report();
    end
endmodule : fcp_regs_bench
